/* uart_defines.svh */
// Overview of operation
// - Full duplex, asynchronous, up to one megabit
// - Optional ninth bit carries generated, checked parity
// - Ready output, clear input, both active low
// - Serial data output idles at high level
// - Framing compatible with conventional standard UARTs
// - Serial data output driven, default high
// - Serial data input has pull-up enabled
// - Ready output driven, default low
// - Clear input has pull-down enabled
// - Host transmit to device input, and back
// - Two independent serial port instances
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH

// Timing
`define UART_CLK_HZ       100000000
`define UART_MAX_BAUD_BPS 1000000
`define UART_MIN_DIV      (`UART_CLK_HZ / `UART_MAX_BAUD_BPS)
`define UART_DIV_W        16

// Reset values
`define UART_DIV_RESET    16'h0364
`define UART_RXD_RESET    1'b1
`define UART_CTS_RESET    1'b0
`define UART_RTS_RESET    1'b0

// Default shape
`define UART_NUM_PORTS    2
`define UART_DATA_BITS    8
`define UART_BUF_DEPTH    2

`endif

/* uart_pkg.sv */
package uart_pkg;

  typedef logic [15:0] div_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PARITY,
    TX_STOP
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_e;

endpackage : uart_pkg

/* uart_skid_buf.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_defines.svh"

module uart_skid_buf #(
  parameter int WIDTH = `UART_DATA_BITS + 2,
  parameter int DEPTH = `UART_BUF_DEPTH
) (
  // Clock
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ff;
  logic [PW-1:0]    nxt_wr;
  logic [PW-1:0]    rd_ff;
  logic [PW-1:0]    nxt_rd;
  logic [CW-1:0]    cnt_ff;
  logic [CW-1:0]    nxt_cnt;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : wrap_inc

  assign in_ready  = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  always_comb begin
    nxt_wr  = push ? wrap_inc(wr_ff) : wr_ff;
    nxt_rd  = pop ? wrap_inc(rd_ff) : rd_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = CW'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = CW'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

endmodule : uart_skid_buf
`default_nettype wire

/* uart_with_flow_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_defines.svh"

module uart_with_flow_control #(
  parameter int NUM_PORTS = `UART_NUM_PORTS,
  parameter int DATA_BITS = `UART_DATA_BITS
) (
  // Clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  input  wire logic                                 clk_en,
  // Per-port configuration
  input  wire uart_pkg::div_t [NUM_PORTS-1:0]      baud_div,
  input  wire logic [NUM_PORTS-1:0]                 parity_en,
  input  wire logic [NUM_PORTS-1:0]                 parity_odd,
  input  wire logic [NUM_PORTS-1:0]                 flow_en,
  // Transmit stream
  input  wire logic [NUM_PORTS-1:0][DATA_BITS-1:0]  tx_data,
  input  wire logic [NUM_PORTS-1:0]                 tx_valid,
  output logic [NUM_PORTS-1:0]                      tx_ready,
  output logic [NUM_PORTS-1:0]                      tx_busy,
  // Receive stream
  output logic [NUM_PORTS-1:0][DATA_BITS-1:0]       rx_data,
  output logic [NUM_PORTS-1:0]                      rx_parity_err,
  output logic [NUM_PORTS-1:0]                      rx_frame_err,
  output logic [NUM_PORTS-1:0]                      rx_valid,
  input  wire logic [NUM_PORTS-1:0]                 rx_ready,
  output logic [NUM_PORTS-1:0]                      rx_overrun,
  // Serial pins
  output logic [NUM_PORTS-1:0]                      txd,
  output logic [NUM_PORTS-1:0]                      txd_oe,
  input  wire logic [NUM_PORTS-1:0]                 rxd,
  output logic [NUM_PORTS-1:0]                      rxd_pull_up,
  output logic [NUM_PORTS-1:0]                      rts_n,
  output logic [NUM_PORTS-1:0]                      rts_n_oe,
  input  wire logic [NUM_PORTS-1:0]                 cts_n,
  output logic [NUM_PORTS-1:0]                      cts_pull_down
);

  localparam int BIT_W = (DATA_BITS > 1) ? $clog2(DATA_BITS) : 1;
  localparam int BUF_W = DATA_BITS + 2;

  // Bit period in clock cycles, never faster than the top rate
  function automatic uart_pkg::div_t eff_div(input uart_pkg::div_t d);
    return (d < 16'(`UART_MIN_DIV)) ? 16'(`UART_MIN_DIV) : d;
  endfunction : eff_div

  // Fixed pin modes: driven outputs, pulled inputs
  assign txd_oe        = '1;
  assign rts_n_oe      = '1;
  assign rxd_pull_up   = '1;
  assign cts_pull_down = '1;

  for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : chan

    // Input synchronisers: s[0] is read only by s[1]
    logic [2:0] rxd_s_ff;
    logic [2:0] nxt_rxd_s;
    logic [2:0] cts_s_ff;
    logic [2:0] nxt_cts_s;
    logic       rxd_f_ff;
    logic       nxt_rxd_f;
    logic       cts_n_f_ff;
    logic       nxt_cts_n_f;
    logic       cts_on;

    always_comb begin
      nxt_rxd_s   = rxd_s_ff;
      nxt_cts_s   = cts_s_ff;
      nxt_rxd_f   = rxd_f_ff;
      nxt_cts_n_f = cts_n_f_ff;
      if (clk_en) begin
        nxt_rxd_s = {rxd_s_ff[1:0], rxd[gp]};
        nxt_cts_s = {cts_s_ff[1:0], cts_n[gp]};
        if (rxd_s_ff[1] == rxd_s_ff[2]) begin
          nxt_rxd_f = rxd_s_ff[2];
        end
        if (cts_s_ff[1] == cts_s_ff[2]) begin
          nxt_cts_n_f = cts_s_ff[2];
        end
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        rxd_s_ff   <= {3{`UART_RXD_RESET}};
        cts_s_ff   <= {3{`UART_CTS_RESET}};
        rxd_f_ff   <= `UART_RXD_RESET;
        cts_n_f_ff <= `UART_CTS_RESET;
      end else begin
        rxd_s_ff   <= nxt_rxd_s;
        cts_s_ff   <= nxt_cts_s;
        rxd_f_ff   <= nxt_rxd_f;
        cts_n_f_ff <= nxt_cts_n_f;
      end
    end

    // Clear-to-send is active low
    assign cts_on = !flow_en[gp] || !cts_n_f_ff;

    // Transmitter
    uart_pkg::tx_state_e   tx_state_ff;
    uart_pkg::tx_state_e   nxt_tx_state;
    uart_pkg::div_t        tx_cnt_ff;
    uart_pkg::div_t        nxt_tx_cnt;
    logic [DATA_BITS-1:0]  tx_shift_ff;
    logic [DATA_BITS-1:0]  nxt_tx_shift;
    logic [BIT_W-1:0]      tx_bit_ff;
    logic [BIT_W-1:0]      nxt_tx_bit;
    logic                  tx_par_ff;
    logic                  nxt_tx_par;
    logic                  txd_ff;
    logic                  nxt_txd;

    assign tx_ready[gp] = clk_en && (tx_state_ff == uart_pkg::TX_IDLE) && cts_on;
    assign tx_busy[gp]  = (tx_state_ff != uart_pkg::TX_IDLE);
    assign txd[gp]      = txd_ff;

    always_comb begin
      nxt_tx_state = tx_state_ff;
      nxt_tx_cnt   = tx_cnt_ff;
      nxt_tx_shift = tx_shift_ff;
      nxt_tx_bit   = tx_bit_ff;
      nxt_tx_par   = tx_par_ff;
      nxt_txd      = txd_ff;
      if (clk_en) begin
        if (tx_state_ff == uart_pkg::TX_IDLE) begin
          nxt_txd = 1'b1;
          if (tx_valid[gp] && cts_on) begin
            nxt_tx_state = uart_pkg::TX_START;
            nxt_tx_cnt   = 16'(eff_div(baud_div[gp]) - 1'b1);
            nxt_tx_shift = tx_data[gp];
            nxt_tx_par   = (^tx_data[gp]) ^ parity_odd[gp];
            nxt_tx_bit   = '0;
            nxt_txd      = 1'b0;
          end
        end else if (tx_cnt_ff != '0) begin
          nxt_tx_cnt = 16'(tx_cnt_ff - 1'b1);
        end else begin
          nxt_tx_cnt = 16'(eff_div(baud_div[gp]) - 1'b1);
          unique case (tx_state_ff)
            uart_pkg::TX_START: begin
              nxt_tx_state = uart_pkg::TX_DATA;
              nxt_txd      = tx_shift_ff[0];
            end
            uart_pkg::TX_DATA: begin
              if (tx_bit_ff == BIT_W'(DATA_BITS - 1)) begin
                nxt_tx_state = parity_en[gp] ? uart_pkg::TX_PARITY : uart_pkg::TX_STOP;
                nxt_txd      = parity_en[gp] ? tx_par_ff : 1'b1;
              end else begin
                nxt_tx_bit   = BIT_W'(tx_bit_ff + 1'b1);
                nxt_tx_shift = tx_shift_ff >> 1;
                nxt_txd      = tx_shift_ff[1];
              end
            end
            uart_pkg::TX_PARITY: begin
              nxt_tx_state = uart_pkg::TX_STOP;
              nxt_txd      = 1'b1;
            end
            uart_pkg::TX_STOP: begin
              nxt_tx_state = uart_pkg::TX_IDLE;
              nxt_txd      = 1'b1;
            end
            uart_pkg::TX_IDLE: begin
              nxt_tx_state = uart_pkg::TX_IDLE;
            end
          endcase
        end
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        tx_state_ff <= uart_pkg::TX_IDLE;
        tx_cnt_ff   <= '0;
        tx_shift_ff <= '0;
        tx_bit_ff   <= '0;
        tx_par_ff   <= 1'b0;
        txd_ff      <= 1'b1;
      end else begin
        tx_state_ff <= nxt_tx_state;
        tx_cnt_ff   <= nxt_tx_cnt;
        tx_shift_ff <= nxt_tx_shift;
        tx_bit_ff   <= nxt_tx_bit;
        tx_par_ff   <= nxt_tx_par;
        txd_ff      <= nxt_txd;
      end
    end

    // Receiver, sampling mid-bit; runs independently of the transmitter
    uart_pkg::rx_state_e   rx_state_ff;
    uart_pkg::rx_state_e   nxt_rx_state;
    uart_pkg::div_t        rx_cnt_ff;
    uart_pkg::div_t        nxt_rx_cnt;
    logic [DATA_BITS-1:0]  rx_shift_ff;
    logic [DATA_BITS-1:0]  nxt_rx_shift;
    logic [BIT_W-1:0]      rx_bit_ff;
    logic [BIT_W-1:0]      nxt_rx_bit;
    logic                  rx_perr_ff;
    logic                  nxt_rx_perr;
    logic                  rx_push;
    logic                  rx_ferr;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic [BUF_W-1:0]      buf_out_data;
    logic                  ovr_ff;
    logic                  nxt_ovr;
    logic                  rts_n_ff;
    logic                  nxt_rts_n;

    always_comb begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_cnt   = rx_cnt_ff;
      nxt_rx_shift = rx_shift_ff;
      nxt_rx_bit   = rx_bit_ff;
      nxt_rx_perr  = rx_perr_ff;
      rx_push      = 1'b0;
      rx_ferr      = 1'b0;
      if (clk_en) begin
        if (rx_state_ff == uart_pkg::RX_IDLE) begin
          if (!rxd_f_ff) begin
            nxt_rx_state = uart_pkg::RX_START;
            nxt_rx_cnt   = 16'((eff_div(baud_div[gp]) >> 1) - 1'b1);
            nxt_rx_perr  = 1'b0;
            nxt_rx_bit   = '0;
          end
        end else if (rx_cnt_ff != '0) begin
          nxt_rx_cnt = 16'(rx_cnt_ff - 1'b1);
        end else begin
          nxt_rx_cnt = 16'(eff_div(baud_div[gp]) - 1'b1);
          unique case (rx_state_ff)
            uart_pkg::RX_START: begin
              // A glitch shorter than half a bit is not a start
              nxt_rx_state = rxd_f_ff ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
            end
            uart_pkg::RX_DATA: begin
              nxt_rx_shift = {rxd_f_ff, rx_shift_ff[DATA_BITS-1:1]};
              if (rx_bit_ff == BIT_W'(DATA_BITS - 1)) begin
                nxt_rx_state = parity_en[gp] ? uart_pkg::RX_PARITY : uart_pkg::RX_STOP;
              end else begin
                nxt_rx_bit = BIT_W'(rx_bit_ff + 1'b1);
              end
            end
            uart_pkg::RX_PARITY: begin
              nxt_rx_perr  = rxd_f_ff ^ (^rx_shift_ff) ^ parity_odd[gp];
              nxt_rx_state = uart_pkg::RX_STOP;
            end
            uart_pkg::RX_STOP: begin
              rx_push      = 1'b1;
              rx_ferr      = !rxd_f_ff;
              nxt_rx_state = uart_pkg::RX_IDLE;
            end
            uart_pkg::RX_IDLE: begin
              nxt_rx_state = uart_pkg::RX_IDLE;
            end
          endcase
        end
      end
      // Word lost when a frame ends with the buffer full: host ignored the handshake, or flow control is off
      nxt_ovr   = clk_en ? (rx_push && !buf_in_ready) : ovr_ff;
      // Hold off the host once a word waits, keeping a slot for one in flight
      nxt_rts_n = clk_en ? (flow_en[gp] && buf_out_valid) : rts_n_ff;
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        rx_state_ff <= uart_pkg::RX_IDLE;
        rx_cnt_ff   <= '0;
        rx_shift_ff <= '0;
        rx_bit_ff   <= '0;
        rx_perr_ff  <= 1'b0;
        ovr_ff      <= 1'b0;
        rts_n_ff    <= `UART_RTS_RESET;
      end else begin
        rx_state_ff <= nxt_rx_state;
        rx_cnt_ff   <= nxt_rx_cnt;
        rx_shift_ff <= nxt_rx_shift;
        rx_bit_ff   <= nxt_rx_bit;
        rx_perr_ff  <= nxt_rx_perr;
        ovr_ff      <= nxt_ovr;
        rts_n_ff    <= nxt_rts_n;
      end
    end

    uart_skid_buf #(
      .WIDTH (BUF_W),
      .DEPTH (`UART_BUF_DEPTH)
    ) u_rx_buf (
      .mclk      (mclk),
      .rst       (rst),
      .clk_en    (clk_en),
      .in_valid  (rx_push),
      .in_ready  (buf_in_ready),
      .in_data   ({rx_perr_ff, rx_ferr, nxt_rx_shift}),
      .out_valid (buf_out_valid),
      .out_ready (rx_ready[gp]),
      .out_data  (buf_out_data)
    );

    assign rx_valid[gp]      = buf_out_valid;
    assign rx_data[gp]       = buf_out_data[DATA_BITS-1:0];
    assign rx_frame_err[gp]  = buf_out_data[DATA_BITS];
    assign rx_parity_err[gp] = buf_out_data[DATA_BITS+1];
    assign rx_overrun[gp]    = ovr_ff;
    assign rts_n[gp]         = rts_n_ff;

    tx_idle_high_a: assert property (@(posedge mclk) disable iff (rst)
      (tx_state_ff == uart_pkg::TX_IDLE) && $past(tx_state_ff == uart_pkg::TX_IDLE) |-> txd_ff)
      else $error("txd low while idle");
    tx_start_low_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(tx_state_ff == uart_pkg::TX_START) |-> !txd_ff && $past(cts_on) && $past(tx_valid[gp]))
      else $error("start bit not low or taken without request");
    tx_stop_high_a: assert property (@(posedge mclk) disable iff (rst)
      (tx_state_ff == uart_pkg::TX_STOP) |-> txd_ff)
      else $error("stop bit not high");
    tx_parity_bit_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(tx_state_ff == uart_pkg::TX_PARITY) |-> txd_ff == tx_par_ff && $past(parity_en[gp]))
      else $error("parity bit wrong");
    tx_cts_gate_a: assert property (@(posedge mclk) disable iff (rst)
      flow_en[gp] && cts_n_f_ff |-> !tx_ready[gp])
      else $error("transmit offered while clear-to-send off");
    tx_bit_time_a: assert property (@(posedge mclk) disable iff (rst)
      $past(clk_en) && $past(tx_state_ff != uart_pkg::TX_IDLE) && (tx_state_ff != $past(tx_state_ff))
      |-> $past(tx_cnt_ff) == '0)
      else $error("transmit bit ended early");
    rts_hold_off_a: assert property (@(posedge mclk) disable iff (rst)
      clk_en && flow_en[gp] && buf_out_valid |=> rts_n_ff)
      else $error("ready not deasserted with word waiting");
    rx_overrun_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(ovr_ff) |-> $past(rx_push) && !$past(buf_in_ready))
      else $error("overrun without a dropped word");
    pin_modes_a: assert property (@(posedge mclk) disable iff (rst)
      txd_oe[gp] && rts_n_oe[gp] && rxd_pull_up[gp] && cts_pull_down[gp])
      else $error("pin mode wrong");
  end

endmodule : uart_with_flow_control
`default_nettype wire

/* host_uart.sv */
`timescale 1ns/10ps
`default_nettype none
module host_uart #(
  parameter int BIT = 100
) (
  // Clock
  input  wire logic        mclk,
  // Device side
  input  wire logic        dev_txd,
  input  wire logic        dev_rts_n,
  input  wire logic        flow_en,
  input  wire logic        par_en,
  output logic             line_out,
  // Received word
  output logic [9:0]       rx_word,
  output logic [15:0]      rx_cnt
);
  initial begin
    line_out = 1'b1;
    rx_word  = 10'h000;
    rx_cnt   = 16'h0000;
  end

  // Holds back each frame while the device says it cannot take more
  task automatic send_frame(input logic [7:0] d, input logic odd, input logic flip);
    logic [10:0] f;
    int          n;
    while (flow_en && dev_rts_n !== 1'b0) @(posedge mclk);
    f = {1'b1, ^d ^ odd ^ flip, d, 1'b0};
    n = par_en ? 11 : 10;
    if (!par_en) f[9] = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      line_out <= f[i];
      repeat (BIT - 1) @(posedge mclk);
    end
  endtask : send_frame

  // Samples each bit of a device frame at its middle
  always begin
    @(posedge mclk);
    if (dev_txd === 1'b0) begin
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk);
        rx_word[i] = dev_txd;
      end
      repeat (BIT) @(posedge mclk);
      rx_word[8] = 1'b0;
      if (par_en) begin
        rx_word[8] = dev_txd;
        repeat (BIT) @(posedge mclk);
      end
      rx_word[9] = dev_txd;
      rx_cnt     = rx_cnt + 16'h0001;
    end
  end
endmodule : host_uart
`default_nettype wire

/* uart_with_flow_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_with_flow_control_bench;
  logic                       mclk          = 1'b0;
  logic                       rst           = 1'b1;
  logic                       clk_en        = 1'b1;
  uart_pkg::div_t [1:0]       baud_div      = {16'h0064, 16'h0064};
  logic [1:0]                 parity_en     = 2'h0;
  logic [1:0]                 parity_odd    = 2'h0;
  logic [1:0]                 flow_en       = 2'h0;
  logic [1:0][7:0]            tx_data       = '0;
  logic [1:0]                 tx_valid      = 2'h0;
  logic [1:0]                 rx_ready      = 2'h0;
  logic [1:0]                 cts_n         = 2'h0;
  logic [1:0]                 tx_ready;
  logic [1:0]                 tx_busy;
  logic [1:0][7:0]            rx_data;
  logic [1:0]                 rx_parity_err;
  logic [1:0]                 rx_frame_err;
  logic [1:0]                 rx_valid;
  logic [1:0]                 rx_overrun;
  logic [1:0]                 txd;
  logic [1:0]                 txd_oe;
  logic [1:0]                 rxd_pull_up;
  logic [1:0]                 rts_n;
  logic [1:0]                 rts_n_oe;
  logic [1:0]                 cts_pull_down;
  wire logic [1:0]            rxd;
  wire logic [1:0][9:0]       hword;
  wire logic [1:0][15:0]      hcnt;
  int                         n_fail        = 0;
  int                         n_tests       = 0;
  int                         n_ovr         = 0;

  always #5 mclk = ~mclk;

  uart_with_flow_control uart_with_flow_control_i (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .baud_div(baud_div), .parity_en(parity_en),
    .parity_odd(parity_odd), .flow_en(flow_en), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
    .txd(txd), .txd_oe(txd_oe), .rxd(rxd), .rxd_pull_up(rxd_pull_up), .rts_n(rts_n),
    .rts_n_oe(rts_n_oe), .cts_n(cts_n), .cts_pull_down(cts_pull_down)
  );

  for (genvar gp = 0; gp < 2; gp++) begin : g_host
    host_uart host_uart_i (
      .mclk(mclk), .dev_txd(txd[gp]), .dev_rts_n(rts_n[gp]), .flow_en(flow_en[gp]),
      .par_en(parity_en[gp]), .line_out(rxd[gp]), .rx_word(hword[gp]), .rx_cnt(hcnt[gp])
    );
  end

  always @(posedge mclk) begin
    if (rx_overrun[0] === 1'b1) n_ovr++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic host_send(input int gp, input logic [7:0] d, input logic flip);
    if (gp == 0) g_host[0].host_uart_i.send_frame(d, parity_odd[0], flip);
    else g_host[1].host_uart_i.send_frame(d, parity_odd[1], flip);
  endtask : host_send

  task automatic pop(input int gp);
    @(posedge mclk);
    rx_ready[gp] <= 1'b1;
    @(posedge mclk);
    rx_ready[gp] <= 1'b0;
  endtask : pop

  // Sends one byte out and judges what the far side caught
  task automatic tx_one(input int gp, input logic [7:0] d);
    logic [15:0] c;
    int          k;
    @(posedge mclk);
    tx_data[gp]  <= d;
    tx_valid[gp] <= 1'b1;
    @(negedge mclk);
    for (k = 0; k < 500 && tx_ready[gp] !== 1'b1; k++) @(negedge mclk);
    chk({15'h0000, k < 500}, 16'h0001);
    c = hcnt[gp];
    @(posedge mclk);
    tx_valid[gp] <= 1'b0;
    @(negedge mclk);
    chk({tx_busy[gp], txd[gp]}, 16'h0002);
    for (k = 0; k < 3000 && hcnt[gp] === c; k++) @(negedge mclk);
    chk({15'h0000, k < 3000}, 16'h0001);
    chk(hword[gp], {7'h01, parity_en[gp] & (^d ^ parity_odd[gp]), d});
    chk(txd[gp], 16'h0001);
  endtask : tx_one

  // Far side sends one byte; the head word must match it
  task automatic rx_one(input int gp, input logic [7:0] d, input logic flip);
    int k;
    host_send(gp, d, flip);
    for (k = 0; k < 300 && rx_valid[gp] !== 1'b1; k++) @(negedge mclk);
    chk({15'h0000, k < 300}, 16'h0001);
    chk({rx_frame_err[gp], rx_parity_err[gp], rx_data[gp]}, {7'h00, flip, d});
    pop(gp);
  endtask : rx_one

  task automatic s_pins;
    chk({txd, rts_n, txd_oe, rts_n_oe, rxd_pull_up, cts_pull_down, rx_valid, tx_busy}, 16'hCFF0);
  endtask : s_pins

  // No parity, even, odd: both ports, both directions at once
  task automatic s_parity;
    logic [7:0] pat [3];
    pat = '{8'h5A, 8'h80, 8'hFF};
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk);
      parity_en  <= (m > 0) ? 2'h3 : 2'h0;
      parity_odd <= (m == 2) ? 2'h3 : 2'h0;
      @(posedge mclk);
      fork
        tx_one(0, pat[m]);
        rx_one(0, ~pat[m], m == 2);
        tx_one(1, ~pat[m]);
        rx_one(1, pat[m], 1'b0);
      join
    end
  endtask : s_parity

  task automatic s_flow;
    int k;
    @(posedge mclk);
    parity_en <= 2'h0;
    flow_en   <= 2'h1;
    @(posedge mclk);
    host_send(0, 8'h3C, 1'b0);
    repeat (4) @(negedge mclk);
    chk(rts_n[0], 16'h0001);
    fork
      host_send(0, 8'hC3, 1'b0);
    join_none
    repeat (1500) @(negedge mclk);
    chk({rxd[0], rx_valid[0], rx_data[0]}, 16'h033C);
    pop(0);
    for (k = 0; k < 3000 && !(rx_valid[0] === 1'b1 && rx_data[0] === 8'hC3); k++) @(negedge mclk);
    chk({15'h0000, k < 3000}, 16'h0001);
    chk(rx_data[0], 16'h00C3);
    pop(0);
    @(posedge mclk);
    cts_n[0] <= 1'b1;
    repeat (6) @(negedge mclk);
    chk({tx_ready[0], rts_n[0]}, 16'h0000);
    @(posedge mclk);
    cts_n[0] <= 1'b0;
    repeat (6) @(negedge mclk);
    chk(tx_ready[0], 16'h0001);
    @(posedge mclk);
    clk_en <= 1'b0;
    @(negedge mclk);
    chk(tx_ready[0], 16'h0000);
    @(posedge mclk);
    clk_en  <= 1'b1;
    flow_en <= 2'h0;
  endtask : s_flow

  // Three words into a two-word buffer with nobody draining
  task automatic s_overrun;
    @(posedge mclk);
    host_send(0, 8'h11, 1'b0);
    host_send(0, 8'h22, 1'b0);
    host_send(0, 8'h33, 1'b0);
    repeat (100) @(negedge mclk);
    chk(16'(n_ovr), 16'h0001);
    chk(rx_data[0], 16'h0011);
    pop(0);
    @(negedge mclk);
    chk(rx_data[0], 16'h0022);
    pop(0);
    @(negedge mclk);
    chk(rx_valid[0], 16'h0000);
  endtask : s_overrun

  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (6) @(negedge mclk);
    s_pins();
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    s_pins();
    s_parity();
    s_flow();
    s_overrun();
    test_done();
  end
endmodule : uart_with_flow_control_bench
`default_nettype wire
